/* File: logic/ioqa_pkg.sv */
/*
  constants, state type and command encodings of the i/o query,
  accumulator math and compare command unit.
  assumes a single 10 MHz clock and frames already checked upstream.
*/
// Operation
// - read-port command is code 15; type picks port, bank byte picks bank.
// - single-line digital reads give 0 or 1; converter reads give 10-bit 0..1023.
// - read-port from stored program copies the value into the accumulator.
// - read-port from host returns value in reply only, accumulator untouched, except bank 0 port 255.
// - good host read-port replies status 100 with the port state as value.
// - bank 0 ports 0..7 return the eight digital input levels.
// - bank 0 port 255 loads all digital inputs as a bit vector.
// - bank 1 gives raw converter values, supply tenths and degrees Celsius.
// - analog lines readable as digital and as converted, with no mode change.
// - bank 2 ports 0..7 return the driven digital output states.
// - bank 0 port 10 returns the driver enable input level.
// - accumulator math is code 19; type picks operation, value is operand.
// - ops: add sub mul div mod and or xor invert load, codes 0..9.
// - host accumulator math replies status 100 echoing the operand.
// - compare is code 20; compares accumulator with operand, sets flags.
// - flags serve conditional jump code 21 with eight conditions.
package ioqa_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] IOQA_OP_READ_PORT = 8'h0f;
  localparam logic [7:0] IOQA_OP_ACCUMULATOR_MATH_CMD = 8'h13;
  localparam logic [7:0] IOQA_OP_COMP = 8'h14;
  localparam logic [7:0] IOQA_OP_JUMP_COND = 8'h15;

  // ==========================================================
  // reply status codes
  localparam logic [7:0] IOQA_ST_OK = 8'h64;
  localparam logic [7:0] IOQA_ST_BAD_CMD = 8'h02;
  localparam logic [7:0] IOQA_ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] IOQA_ST_BAD_VALUE = 8'h04;

  // ==========================================================
  // banks and special ports
  localparam logic [7:0] IOQA_BANK_DIN = 8'h00;
  localparam logic [7:0] IOQA_BANK_ANA = 8'h01;
  localparam logic [7:0] IOQA_BANK_DOUT = 8'h02;
  localparam logic [7:0] IOQA_PORT_LAST_LINE = 8'h07;
  localparam logic [7:0] IOQA_PORT_SUPPLY = 8'h08;
  localparam logic [7:0] IOQA_PORT_TEMP = 8'h09;
  localparam logic [7:0] IOQA_PORT_ENABLE = 8'h0a;
  localparam logic [7:0] IOQA_PORT_ALL = 8'hff;

  // ==========================================================
  // accumulator math operations
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_ADD = 8'h00;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_SUB = 8'h01;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_MUL = 8'h02;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_DIV = 8'h03;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_MOD = 8'h04;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_AND = 8'h05;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_OR = 8'h06;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_XOR = 8'h07;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_NOT = 8'h08;
  localparam logic [7:0] IOQA_ACCUMULATOR_MATH_CMD_LOAD = 8'h09;

  // ==========================================================
  // conditional jump conditions
  localparam logic [3:0] IOQA_CC_ZE = 4'h0;
  localparam logic [3:0] IOQA_CC_NZ = 4'h1;
  localparam logic [3:0] IOQA_CC_EQ = 4'h2;
  localparam logic [3:0] IOQA_CC_NE = 4'h3;
  localparam logic [3:0] IOQA_CC_GT = 4'h4;
  localparam logic [3:0] IOQA_CC_GE = 4'h5;
  localparam logic [3:0] IOQA_CC_LT = 4'h6;
  localparam logic [3:0] IOQA_CC_LE = 4'h7;

  // ==========================================================
  // widths and reset values
  localparam int IOQA_ADC_BITS = 10;
  localparam logic [31:0] IOQA_ACC_RST = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] acc;
    logic f_zero;
    logic f_gt;
    logic f_lt;
    logic rsp_valid;
    logic [7:0] rsp_status;
    logic [7:0] rsp_opcode;
    logic [31:0] rsp_value;
  } ioqa_state_t;

endpackage : ioqa_pkg

/* File: logic/ioqa_sync.sv */
/*
  three-stage pin synchroniser with agreement filter.
  assumes asynchronous pin levels; output moves once stages two and
  three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module ioqa_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [W-1:0] pin_in, // raw pin levels
  output logic [W-1:0] lvl_out // filtered level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ioqa_sync_t;

  ioqa_sync_t r_q;
  ioqa_sync_t r_d;

  // ==========================================================
  // next state
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.lvl[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign lvl_out = r_q.lvl;

endmodule : ioqa_sync
`default_nettype wire

/* File: logic/ioqa_core.sv */
/*
  executes read-port, accumulator math and compare commands.
  assumes frames arrive decoded and checked, one per cycle at most;
  converter values and output states come from logic on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ioqa_core
  import ioqa_pkg::*;
(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic cmd_valid, // command present
  output logic cmd_ready, // command accepted this cycle
  input wire logic cmd_standalone, // 1 = from stored program
  input wire logic [7:0] cmd_opcode, // instruction code
  input wire logic [7:0] cmd_type, // type byte
  input wire logic [7:0] cmd_bank, // motor/bank byte
  input wire logic [31:0] cmd_value, // value, assembled msb first
  output logic rsp_valid, // one-cycle reply strobe
  output logic [7:0] rsp_status, // reply status
  output logic [7:0] rsp_opcode, // reply instruction
  output logic [31:0] rsp_value, // reply value
  input wire logic [7:0] digital_input, // general inputs, pins
  input wire logic drv_enable, // driver enable pin
  input wire logic [7:0] digital_output, // driven output states
  input wire logic [7:0][9:0] adc_raw, // raw conversion per channel
  input wire logic [15:0] supply_dv, // supply, tenths of a volt
  input wire logic signed [15:0] temp_c, // temperature, degrees C
  output logic [31:0] acc, // accumulator
  output logic flag_zero, // compare/result zero
  output logic flag_gt, // greater
  output logic flag_lt, // lower
  input wire logic [3:0] cond_sel, // jump condition code
  output logic cond_met // condition holds
);

  ioqa_state_t r_q;
  ioqa_state_t r_d;

  logic [7:0] din_s;
  logic en_s;

  // ==========================================================
  // pin synchronisers
  ioqa_sync #(.W(9)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in({drv_enable, digital_input}),
    .lvl_out({en_s, din_s})
  );

  assign cmd_ready = 1'b1;

  // ==========================================================
  // port read decode
  logic [31:0] rd_val;
  logic rd_ok;
  logic rd_bulk;

  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b0;
    rd_bulk = 1'b0;
    case (cmd_bank)
      IOQA_BANK_DIN: begin
        if (cmd_type <= IOQA_PORT_LAST_LINE) begin
          rd_val = {31'h0, din_s[cmd_type[2:0]]};
          rd_ok = 1'b1;
        end else if (cmd_type == IOQA_PORT_ENABLE) begin
          rd_val = {31'h0, en_s};
          rd_ok = 1'b1;
        end else if (cmd_type == IOQA_PORT_ALL) begin
          rd_val = {24'h0, din_s};
          rd_ok = 1'b1;
          rd_bulk = 1'b1;
        end
      end
      IOQA_BANK_ANA: begin
        if (cmd_type <= IOQA_PORT_LAST_LINE) begin
          rd_val = {22'h0, adc_raw[cmd_type[2:0]]};
          rd_ok = 1'b1;
        end else if (cmd_type == IOQA_PORT_SUPPLY) begin
          rd_val = {16'h0, supply_dv};
          rd_ok = 1'b1;
        end else if (cmd_type == IOQA_PORT_TEMP) begin
          rd_val = {{16{temp_c[15]}}, temp_c};
          rd_ok = 1'b1;
        end
      end
      IOQA_BANK_DOUT: begin
        if (cmd_type <= IOQA_PORT_LAST_LINE) begin
          rd_val = {31'h0, digital_output[cmd_type[2:0]]};
          rd_ok = 1'b1;
        end
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // accumulator math
  logic signed [31:0] a_s;
  logic signed [31:0] b_s;
  logic [31:0] res;
  logic res_ok;

  assign a_s = $signed(r_q.acc);
  assign b_s = $signed(cmd_value);

  always_comb begin
    res = r_q.acc;
    res_ok = 1'b1;
    case (cmd_type)
      IOQA_ACCUMULATOR_MATH_CMD_ADD: res = 32'(a_s + b_s);
      IOQA_ACCUMULATOR_MATH_CMD_SUB: res = 32'(a_s - b_s);
      IOQA_ACCUMULATOR_MATH_CMD_MUL: res = 32'(a_s * b_s);
      IOQA_ACCUMULATOR_MATH_CMD_DIV: begin
        if (b_s == 32'sh0) begin
          res_ok = 1'b0;
        end else begin
          res = 32'(a_s / b_s);
        end
      end
      IOQA_ACCUMULATOR_MATH_CMD_MOD: begin
        if (b_s == 32'sh0) begin
          res_ok = 1'b0;
        end else begin
          res = 32'(a_s % b_s);
        end
      end
      IOQA_ACCUMULATOR_MATH_CMD_AND: res = r_q.acc & cmd_value;
      IOQA_ACCUMULATOR_MATH_CMD_OR: res = r_q.acc | cmd_value;
      IOQA_ACCUMULATOR_MATH_CMD_XOR: res = r_q.acc ^ cmd_value;
      IOQA_ACCUMULATOR_MATH_CMD_NOT: res = ~r_q.acc;
      IOQA_ACCUMULATOR_MATH_CMD_LOAD: res = cmd_value;
      default: res_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // command execution
  always_comb begin
    r_d = r_q;
    r_d.rsp_valid = 1'b0;
    if (cmd_valid) begin
      r_d.rsp_valid = 1'b1;
      r_d.rsp_opcode = cmd_opcode;
      r_d.rsp_value = 32'h0;
      r_d.rsp_status = IOQA_ST_OK;
      case (cmd_opcode)
        IOQA_OP_READ_PORT: begin
          if (rd_ok) begin
            r_d.rsp_value = rd_val;
            if (cmd_standalone || rd_bulk) begin
              r_d.acc = rd_val;
              r_d.f_zero = (rd_val == 32'h0);
              r_d.f_gt = ($signed(rd_val) > 32'sh0);
              r_d.f_lt = rd_val[31];
            end
          end else begin
            r_d.rsp_status = IOQA_ST_BAD_TYPE;
          end
        end
        IOQA_OP_ACCUMULATOR_MATH_CMD: begin
          r_d.rsp_value = cmd_value;
          if (res_ok) begin
            r_d.acc = res;
            r_d.f_zero = (res == 32'h0);
            r_d.f_gt = ($signed(res) > 32'sh0);
            r_d.f_lt = res[31];
          end else if (cmd_type > IOQA_ACCUMULATOR_MATH_CMD_LOAD) begin
            r_d.rsp_status = IOQA_ST_BAD_TYPE;
          end else begin
            r_d.rsp_status = IOQA_ST_BAD_VALUE;
          end
        end
        IOQA_OP_COMP: begin
          r_d.f_zero = (a_s == b_s);
          r_d.f_gt = (a_s > b_s);
          r_d.f_lt = (a_s < b_s);
        end
        default: begin
          r_d.rsp_status = IOQA_ST_BAD_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q <= '{acc: IOQA_ACC_RST, rsp_status: IOQA_ST_OK, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // conditional jump evaluation
  always_comb begin
    case (cond_sel)
      IOQA_CC_ZE, IOQA_CC_EQ: cond_met = r_q.f_zero;
      IOQA_CC_NZ, IOQA_CC_NE: cond_met = !r_q.f_zero;
      IOQA_CC_GT: cond_met = r_q.f_gt;
      IOQA_CC_GE: cond_met = r_q.f_gt | r_q.f_zero;
      IOQA_CC_LT: cond_met = r_q.f_lt;
      IOQA_CC_LE: cond_met = r_q.f_lt | r_q.f_zero;
      default: cond_met = 1'b0;
    endcase
  end

  assign rsp_valid = r_q.rsp_valid;
  assign rsp_status = r_q.rsp_status;
  assign rsp_opcode = r_q.rsp_opcode;
  assign rsp_value = r_q.rsp_value;
  assign acc = r_q.acc;
  assign flag_zero = r_q.f_zero;
  assign flag_gt = r_q.f_gt;
  assign flag_lt = r_q.f_lt;

endmodule : ioqa_core
`default_nettype wire

/* File: dv/ioqa_core_chk.sv */
/* assertions on the ports of the command unit.
   assumes the bind below attaches it to every ioqa_core. */
`timescale 1ns/1ns
`default_nettype none
module ioqa_core_chk
  import ioqa_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset, low
  input wire logic cmd_valid, // command
  input wire logic cmd_standalone, // program
  input wire logic [7:0] cmd_opcode, // code
  input wire logic [7:0] cmd_type, // type
  input wire logic [7:0] cmd_bank, // bank
  input wire logic [31:0] cmd_value, // operand
  input wire logic rsp_valid, // reply
  input wire logic [7:0] rsp_status, // status
  input wire logic [31:0] rsp_value, // value
  input wire logic [7:0][9:0] adc_raw, // converter
  input wire logic [31:0] acc, // accumulator
  input wire logic flag_zero, // zero
  input wire logic flag_gt, // greater
  input wire logic [3:0] cond_sel, // condition
  input wire logic cond_met // met
);
  // ==========================================================
  // decode
  logic rd, cl, ana;
  logic [31:0] ana_v;
  assign rd = cmd_valid && cmd_opcode == IOQA_OP_READ_PORT;
  assign cl = cmd_valid && cmd_opcode == IOQA_OP_ACCUMULATOR_MATH_CMD;
  assign ana = rd && cmd_bank == IOQA_BANK_ANA && cmd_type < 8'h08;
  assign ana_v = {22'h0, adc_raw[cmd_type[2:0]]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // properties
  property p_reply;
    cmd_valid |=> rsp_valid;
  endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_ana_acc;
    ana && cmd_standalone |=> acc == $past(ana_v);
  endproperty
  a_ana_acc: assert property (p_ana_acc) else $error("acc load");
  property p_direct;
    rd && !cmd_standalone && cmd_type != IOQA_PORT_ALL |=> $stable(acc);
  endproperty
  a_direct: assert property (p_direct) else $error("acc moved");
  property p_bulk;
    rd && cmd_bank == IOQA_BANK_DIN && cmd_type == IOQA_PORT_ALL
      |=> acc[31:8] == 24'h0;
  endproperty
  a_bulk: assert property (p_bulk) else $error("bulk upper");
  property p_echo;
    cl && cmd_type < 8'h03 |=> rsp_status == IOQA_ST_OK
      && rsp_value == $past(cmd_value);
  endproperty
  a_echo: assert property (p_echo) else $error("accumulator_math_cmd echo");
  property p_add;
    cl && cmd_type == IOQA_ACCUMULATOR_MATH_CMD_ADD |=> acc == $past(acc) + $past(cmd_value);
  endproperty
  a_add: assert property (p_add) else $error("add result");
  property p_comp;
    cmd_valid && cmd_opcode == IOQA_OP_COMP |=> $stable(acc)
      && flag_zero == ($past(acc) == $past(cmd_value));
  endproperty
  a_comp: assert property (p_comp) else $error("compare");
  property p_ge;
    cond_sel == IOQA_CC_GE |-> cond_met == (flag_gt || flag_zero);
  endproperty
  a_ge: assert property (p_ge) else $error("ge cond");
endmodule : ioqa_core_chk
bind ioqa_core ioqa_core_chk u_ioqa_core_chk (.clk_sys(clk_sys),
  .nrst(nrst), .cmd_valid(cmd_valid), .cmd_standalone(cmd_standalone),
  .cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
  .cmd_value(cmd_value), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
  .rsp_value(rsp_value), .adc_raw(adc_raw), .acc(acc),
  .flag_zero(flag_zero), .flag_gt(flag_gt), .cond_sel(cond_sel),
  .cond_met(cond_met));
`default_nettype wire

/* File: dv/ioqa_host.sv */
/* host side model: drives command fields toward the unit.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module ioqa_host
  import ioqa_pkg::*;
(
  input wire logic clk_sys, // clock
  output logic cmd_valid, // command present
  output logic cmd_standalone, // program source
  output logic [7:0] cmd_opcode, // code
  output logic [7:0] cmd_type, // type
  output logic [7:0] cmd_bank, // bank
  output logic [31:0] cmd_value // operand
);
  // ==========================================================
  // command driver
  initial begin
    cmd_valid = 1'b0;
    cmd_standalone = 1'b0;
    cmd_opcode = 8'h00;
    cmd_type = 8'h00;
    cmd_bank = 8'h00;
    cmd_value = 32'h0;
  end
  // holds the command over one taking edge; back to back is legal
  task automatic issue(input logic sa, input logic [7:0] op, ty, bk,
                       input logic [31:0] val);
    cmd_valid = 1'b1;
    cmd_standalone = sa || op == IOQA_OP_COMP;
    cmd_opcode = op;
    cmd_type = ty;
    cmd_bank = bk;
    cmd_value = val;
    @(posedge clk_sys);
    #1;
  endtask : issue
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_value = ~cmd_value;
  endtask : idle
endmodule : ioqa_host
`default_nettype wire

/* File: dv/ioqa_core_tb_top.sv */
/* bench for the command unit: table of host reads and math, then
   program reads, compare, error and reset cases.
   assumes ioqa_host drives the command fields. */
`timescale 1ns/1ns
`default_nettype none
module ioqa_core_tb_top
  import ioqa_pkg::*;
();
  typedef struct packed {
    logic [7:0] op, ty, bk;
    logic [31:0] val;
    logic [7:0] st;
    logic [31:0] rv;
  } ioqa_row_t;
  logic clk_sys, nrst, cmd_valid, cmd_standalone, rsp_valid, drv_enable;
  logic [7:0] cmd_opcode, cmd_type, cmd_bank, rsp_status;
  logic [7:0] digital_input, digital_output;
  logic [31:0] cmd_value, rsp_value, acc, ea;
  logic [7:0][9:0] adc_raw;
  logic [15:0] supply_dv;
  logic signed [15:0] temp_c;
  logic flag_zero, cond_met;
  logic cmd_ready, flag_gt, flag_lt, ez;
  logic [7:0] rsp_opcode;
  logic signed [31:0] ld_v = 32'hffff_fff9;
  logic [3:0] cond_sel;
  logic [31:0] cv [3] = '{32'h5, 32'hffff_fff9, 32'hffff_fff7};
  logic [7:0] cm [3] = '{8'hca, 8'ha5, 8'h3a};
  ioqa_row_t rows [$];
  int err_count = 0;
  int tests_run = 0;
  ioqa_core u_ioqa_core (.clk_sys(clk_sys), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_standalone(cmd_standalone),
    .cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
    .cmd_value(cmd_value), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_opcode(rsp_opcode), .rsp_value(rsp_value),
    .digital_input(digital_input),
    .drv_enable(drv_enable), .digital_output(digital_output),
    .adc_raw(adc_raw), .supply_dv(supply_dv), .temp_c(temp_c), .acc(acc),
    .flag_zero(flag_zero), .flag_gt(flag_gt), .flag_lt(flag_lt),
    .cond_sel(cond_sel), .cond_met(cond_met));
  ioqa_host u_ioqa_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_standalone(cmd_standalone), .cmd_opcode(cmd_opcode),
    .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value));
  // ==========================================================
  // helpers
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [31:0] accumulator_math_cmd(logic [31:0] a, logic [7:0] t,
                                       logic [31:0] b);
    case (t)
      8'h00: return a + b;
      8'h01: return a - b;
      8'h02: return a * b;
      8'h03: return $signed(a) / $signed(b);
      8'h04: return $signed(a) % $signed(b);
      8'h05: return a & b;
      8'h06: return a | b;
      8'h07: return a ^ b;
      8'h08: return ~a;
      default: return b;
    endcase
  endfunction : accumulator_math_cmd
  task automatic do_reset(int n);
    nrst = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    ea = 32'h0;
    ez = 1'b0;
    chk("acc", acc, 32'h0);
    chk("status", 32'(rsp_status), 32'(IOQA_ST_OK));
    chk("rsp_valid", 32'(rsp_valid), 32'h0);
    chk("zero", 32'(flag_zero), 32'h0);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : do_reset
  // ==========================================================
  // stimulus
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #(100 * 2000);
    err_count++;
    wrap_up();
  end
  initial begin
    drv_enable = 1'b1;
    digital_input = 8'h3c;
    digital_output = 8'ha5;
    supply_dv = 16'h00f0;
    temp_c = 16'sh0019;
    cond_sel = 4'h0;
    for (int i = 0; i < 8; i++) begin
      adc_raw[i] = 10'h3f8 + 10'(i);
      rows.push_back('{IOQA_OP_READ_PORT, 8'(i), IOQA_BANK_ANA, 32'h0,
        IOQA_ST_OK, 32'(adc_raw[i])});
      rows.push_back('{IOQA_OP_READ_PORT, 8'(i), IOQA_BANK_DIN, 32'h0,
        IOQA_ST_OK, 32'(digital_input[i])});
      rows.push_back('{IOQA_OP_READ_PORT, 8'(i), IOQA_BANK_DOUT, 32'h0,
        IOQA_ST_OK, 32'(digital_output[i])});
    end
    rows.push_back('{8'h0f, 8'h08, 8'h01, 32'h0, 8'h64, 32'h00f0});
    rows.push_back('{8'h0f, 8'h09, 8'h01, 32'h0, 8'h64, 32'h0019});
    rows.push_back('{8'h0f, 8'h0a, 8'h00, 32'h0, 8'h64, 32'h1});
    rows.push_back('{8'h0f, 8'h0a, 8'h01, 32'h0, 8'h03, 32'h0});
    for (int i = 0; i < 10; i++) begin
      rows.push_back('{IOQA_OP_ACCUMULATOR_MATH_CMD, 8'(i), 8'h00, 32'(i + 3),
        IOQA_ST_OK, 32'(i + 3)});
    end
    do_reset(6);
    foreach (rows[k]) begin
      u_ioqa_host.issue(1'b0, rows[k].op, rows[k].ty, rows[k].bk,
        rows[k].val);
      if (rows[k].op == IOQA_OP_ACCUMULATOR_MATH_CMD) begin
        ea = accumulator_math_cmd(ea, rows[k].ty, rows[k].val);
        ez = (ea == 32'h0);
      end
      chk("ready", 32'(cmd_ready), 32'h1);
      chk("rsp_valid", 32'(rsp_valid), 32'h1);
      chk("status", 32'(rsp_status), 32'(rows[k].st));
      chk("opcode", 32'(rsp_opcode), 32'(rows[k].op));
      chk("value", rsp_value, rows[k].rv);
      chk("acc", acc, ea);
      chk("zero", 32'(flag_zero), 32'(ez));
    end
    u_ioqa_host.idle();
    drv_enable = 1'b0;
    digital_input = 8'hc3;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("rsp_valid", 32'(rsp_valid), 32'h0);
    u_ioqa_host.issue(1'b0, 8'h0f, IOQA_PORT_ENABLE, 8'h00, 32'h0);
    chk("enable", rsp_value, 32'h0);
    u_ioqa_host.issue(1'b1, 8'h0f, 8'h07, IOQA_BANK_ANA, 32'h0);
    chk("acc", acc, 32'h3ff);
    u_ioqa_host.issue(1'b0, 8'h0f, IOQA_PORT_ALL, IOQA_BANK_DIN, 32'h0);
    chk("acc", acc, 32'h0000_00c3);
    u_ioqa_host.issue(1'b0, IOQA_OP_JUMP_COND, 8'h00, 8'h00, 32'h0);
    chk("status", 32'(rsp_status), 32'(IOQA_ST_BAD_CMD));
    u_ioqa_host.issue(1'b1, 8'h13, 8'h0a, 8'h00, 32'h1);
    chk("status", 32'(rsp_status), 32'(IOQA_ST_BAD_TYPE));
    u_ioqa_host.issue(1'b1, 8'h13, IOQA_ACCUMULATOR_MATH_CMD_DIV, 8'h00, 32'h0);
    chk("status", 32'(rsp_status), 32'(IOQA_ST_BAD_VALUE));
    chk("acc", acc, 32'h0000_00c3);
    u_ioqa_host.issue(1'b1, 8'h13, IOQA_ACCUMULATOR_MATH_CMD_LOAD, 8'h00, 32'hffff_fff9);
    foreach (cv[j]) begin
      u_ioqa_host.issue(1'b1, IOQA_OP_COMP, 8'h00, 8'h00, cv[j]);
      u_ioqa_host.idle();
      chk("acc", acc, 32'hffff_fff9);
      chk("gt", 32'(flag_gt), 32'(ld_v > $signed(cv[j])));
      chk("lt", 32'(flag_lt), 32'(ld_v < $signed(cv[j])));
      for (int c = 0; c < 8; c++) begin
        cond_sel = 4'(c);
        @(posedge clk_sys);
        #1;
        chk("cond_met", 32'(cond_met), 32'(cm[j][c]));
      end
    end
    cond_sel = 4'h8;
    @(posedge clk_sys);
    #1;
    chk("cond_met", 32'(cond_met), 32'h0);
    u_ioqa_host.idle();
    do_reset(2);
    wrap_up();
  end
endmodule : ioqa_core_tb_top
`default_nettype wire
